// ### core/trib_out_pkg.sv
package trib_out_pkg;

	localparam int LANE_N = 4;
	localparam int STS_N = 3;
	localparam int PTR_W = 10;
	localparam int GROUP_N = 3;
	localparam int SYNC_STAGES = 2;
	// input byte to downstream sample, in byte clock edges
	localparam int PIPE_CYCLES = 7;
	// stages held in the lane delay line, sync flops included
	localparam int LANE_DELAY = PIPE_CYCLES - 2;

	////////////////////////////////////////////////////////////////
	// sts-3 transport frame geometry
	localparam logic [3:0] ROW_LAST = 4'h8;
	localparam logic [8:0] COL_LAST = 9'h10d;
	localparam logic [8:0] TOH_COLS = 9'h009;
	localparam logic [3:0] C1_ROW = 4'h0;
	localparam logic [8:0] C1_COL = 9'h006;
	localparam logic [3:0] PAY_ROW0 = 4'h3;

	////////////////////////////////////////////////////////////////
	// envelope geometry
	localparam logic [11:0] AU3_SPE_LEN = 12'h30f;
	localparam logic [11:0] AU4_SPE_LEN = 12'h92d;
	localparam logic [11:0] AU4_PTR_UNIT = 12'h003;
	localparam logic [11:0] J1_TO_V1 = 12'h003;
	localparam logic [11:0] MF_AU4_OFS = 12'h001;
	localparam logic [8:0] AU3_SPE_COL_LAST = 9'h056;
	localparam logic [8:0] AU4_SPE_COL_LAST = 9'h104;
	localparam logic [8:0] AU3_STUFF_A = 9'h01d;
	localparam logic [8:0] AU3_STUFF_B = 9'h03a;
	localparam logic [8:0] AU3_TRIB_FIRST = 9'h001;
	localparam logic [8:0] AU3_TRIB_LAST = 9'h01c;
	localparam logic [8:0] AU4_STUFF_LAST = 9'h002;
	localparam logic [8:0] AU4_TRIB_FIRST = 9'h003;
	localparam logic [8:0] AU4_TRIB_LAST = 9'h056;
	localparam logic [3:0] VBYTE_ROW = 4'h0;
	localparam logic [3:0] POH_ROW = 4'h1;
	localparam logic [1:0] V5_PHASE = 2'h0;

	typedef enum logic [1:0] {
		MODE_STM1 = 2'b01,
		MODE_STM4 = 2'b10
	} out_mode_t;

endpackage

// ### core/delay_line.sv
`timescale 1ns/1ps
`default_nettype none
module delay_line #(
	parameter int W = 8,
	parameter int DEPTH = 2
) (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	logic [W-1:0] stageQ [DEPTH];

	// plain shift chain; the first stage feeds only the second
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			for (int j = 0; j < DEPTH; j++) begin
				stageQ[j] <= '0;
			end
		end else begin
			stageQ[0] <= din;
			for (int j = 1; j < DEPTH; j++) begin
				stageQ[j] <= stageQ[j-1];
			end
		end
	end

	assign dout = stageQ[DEPTH-1];
endmodule // delay_line
`default_nettype wire

// ### core/sts3_frame_counter.sv
`timescale 1ns/1ps
`default_nettype none
module sts3_frame_counter (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic advance,
	input wire logic c1Load,
	output logic [3:0] rowQ,
	output logic [8:0] colQ,
	output logic [1:0] stsQ
);
	import trib_out_pkg::*;

	// load wins over advance: the byte before c1 is the one dropped
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rowQ <= 4'h0;
			colQ <= 9'h000;
			stsQ <= 2'h0;
		end else if (c1Load) begin
			rowQ <= C1_ROW;
			colQ <= C1_COL;
			stsQ <= 2'h0;
		end else if (advance) begin
			if (colQ == COL_LAST) begin
				colQ <= 9'h000;
				rowQ <= (rowQ == ROW_LAST) ? 4'h0 : rowQ + 4'h1;
			end else begin
				colQ <= colQ + 9'h001;
			end
			stsQ <= (stsQ == 2'h2) ? 2'h0 : stsQ + 2'h1;
		end
	end
endmodule // sts3_frame_counter
`default_nettype wire

// ### core/tributary_output_bus_timing.sv
`timescale 1ns/1ps
`default_nettype none
module tributary_output_bus_timing (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic out_low_rate_select,
	input wire logic [31:0] in_data_bus,
	input wire logic [3:0] in_frame_marker,
	input wire logic [3:0] in_payload_ind,
	input wire logic [3:0] out_multiframe_in,
	input wire logic [3:0] au4Mode,
	input wire logic [3:0][trib_out_pkg::PTR_W-1:0] outPointer,
	input wire logic [3:0][trib_out_pkg::GROUP_N-1:0] group_enable_bit,
	input wire logic [3:0][trib_out_pkg::GROUP_N-1:0] group_bypass_bit,
	output logic [31:0] out_data_bus,
	output logic [3:0] out_frame_marker,
	output logic [3:0] out_payload_ind,
	output logic [3:0] out_trib_payload_ind,
	output logic [3:0] out_trib_start_mark,
	output logic [3:0] out_trib_overhead_mark
);
	import trib_out_pkg::*;

	////////////////////////////////////////////////////////////////
	// input pipeline and synchronisers
	logic [47:0] laneIn;
	logic [47:0] laneDly;
	logic [4:0] ctlSync;
	logic [31:0] dataS6Q;
	logic [3:0] c1Det;
	logic [1:0] slotQ;
	out_mode_t modeNow;
	logic stm1;
	logic [3:0] mfNow;

	generate
		for (genvar l = 0; l < LANE_N; l++) begin : gPack
			// two spare bits pad each lane slot to twelve
			assign laneIn[l*12 +: 12] = {2'h0, in_data_bus[l*8 +: 8], in_frame_marker[l],
				in_payload_ind[l]};
			// c1 is the frame marker with payload low
			assign c1Det[l] = laneDly[l*12 + 1] & ~laneDly[l*12];
		end
	endgenerate

	// pins captured first by the two sync stages
	delay_line #(
		.W(48),
		.DEPTH(LANE_DELAY)
	) uLaneDelay (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.din(laneIn),
		.dout(laneDly)
	);

	delay_line #(
		.W(5),
		.DEPTH(SYNC_STAGES)
	) uCtlSync (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.din({out_low_rate_select, out_multiframe_in}),
		.dout(ctlSync)
	);

	assign modeNow = ctlSync[4] ? MODE_STM1 : MODE_STM4;
	assign stm1 = (modeNow == MODE_STM1);
	// stm-4 reads the multiframe flag from lane zero only
	assign mfNow = stm1 ? ctlSync[3:0] : {4{ctlSync[0]}};

	// sixth stage; the output register is the seventh
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			dataS6Q <= 32'h00000000;
		end else begin
			for (int l = 0; l < LANE_N; l++) begin
				dataS6Q[l*8 +: 8] <= laneDly[l*12+2 +: 8];
			end
		end
	end

	// byte slot walks the four interleaved sts-3 streams
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			slotQ <= 2'h0;
		end else if (c1Det[0]) begin
			slotQ <= 2'h0;
		end else begin
			slotQ <= slotQ + 2'h1;
		end
	end

	////////////////////////////////////////////////////////////////
	// per sts-3 stream timing
	logic [3:0] sFrame;
	logic [3:0] sPay;
	logic [3:0] sTribPay;
	logic [3:0] sStart;
	logic [3:0] sPoh;

	function automatic logic [11:0] wrapAdd(input logic [11:0] a, input logic [11:0] b,
		input logic [11:0] len);
		logic [11:0] s;
		s = a + b;
		return (s >= len) ? s - len : s;
	endfunction

	generate
		for (genvar i = 0; i < LANE_N; i++) begin : gStream
			logic advance;
			logic c1Load;
			logic [3:0] rowQ;
			logic [8:0] colQ;
			logic [1:0] stsQ;
			logic [1:0] tugQ;
			logic [1:0] mfPhaseQ;
			logic [11:0] kCntQ [STS_N];
			logic [8:0] speColQ [STS_N];
			logic [3:0] speRowQ [STS_N];
			logic [1:0] si;
			logic [1:0] grp;
			logic isPay;
			logic firstPay;
			logic isJ1;
			logic isV1m;
			logic mfSample;
			logic tribArea;
			logic firstCol;
			logic vByte;
			logic pohByte;
			logic groupOn;
			logic [11:0] kEff;
			logic [11:0] spanLen;
			logic [11:0] tgt;
			logic [8:0] sCol;
			logic [8:0] colLast;
			logic [3:0] sRow;

			// one stream per lane, stepping every edge in stm-1
			assign advance = stm1 | (slotQ == 2'(i));
			// frame phase taken from the delayed input c1
			assign c1Load = stm1 ? c1Det[i] : c1Det[0];

			sts3_frame_counter uFrame (
				.ref_clk(ref_clk),
				.nrst(nrst),
				.advance(advance),
				.c1Load(c1Load),
				.rowQ(rowQ),
				.colQ(colQ),
				.stsQ(stsQ)
			);

			always_comb begin
				// au4 uses one pointer for all three sts-1s
				si = au4Mode[i] ? 2'h0 : stsQ;
				// payload is every column past transport overhead
				isPay = (colQ >= TOH_COLS);
				firstPay = (rowQ == PAY_ROW0) && (colQ == TOH_COLS + {7'h00, si});
				kEff = firstPay ? 12'h000 : kCntQ[si];
				spanLen = au4Mode[i] ? AU4_SPE_LEN : AU3_SPE_LEN;
				// pointer places j1, au4 in units of three
				tgt = au4Mode[i] ? ({2'h0, outPointer[i]} * AU4_PTR_UNIT)
					: {2'h0, outPointer[i]};
				isJ1 = isPay && (kEff == tgt);
				isV1m = isPay && (kEff == wrapAdd(tgt, J1_TO_V1, spanLen));
				sCol = isJ1 ? 9'h000 : speColQ[si];
				sRow = isJ1 ? 4'h0 : speRowQ[si];
				colLast = au4Mode[i] ? AU4_SPE_COL_LAST : AU3_SPE_COL_LAST;
				// one au4 layout serves tug3 and tu3 alike
				tribArea = au4Mode[i] ? (sCol >= AU4_TRIB_FIRST)
					: (sCol != 9'h000 && sCol != AU3_STUFF_A && sCol != AU3_STUFF_B);
				firstCol = au4Mode[i] ? (sCol >= AU4_TRIB_FIRST && sCol <= AU4_TRIB_LAST)
					: (sCol >= AU3_TRIB_FIRST && sCol <= AU3_TRIB_LAST);
				vByte = isPay && firstCol && (sRow == VBYTE_ROW);
				pohByte = isPay && firstCol && (sRow == POH_ROW);
				// multiframe sampling point per payload mode
				mfSample = au4Mode[i] ? (isPay && kEff == wrapAdd(tgt, MF_AU4_OFS, spanLen))
					: (si == 2'h0 && vByte && sCol == AU3_TRIB_FIRST);
				// group is the sts-1 in au3, the tug3 in au4
				grp = au4Mode[i] ? tugQ : stsQ;
				groupOn = group_enable_bit[i][grp] & ~group_bypass_bit[i][grp];
			end

			// envelope byte counters restarted at the first payload byte, spe row and column at each j1
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					tugQ <= 2'h0;
					for (int s = 0; s < STS_N; s++) begin
						kCntQ[s] <= 12'h000;
						speColQ[s] <= 9'h000;
						speRowQ[s] <= 4'h0;
					end
				end else if (advance && !c1Load && isPay) begin
					kCntQ[si] <= wrapAdd(kEff, 12'h001, spanLen);
					if (sCol == colLast) begin
						speColQ[si] <= 9'h000;
						speRowQ[si] <= (sRow == ROW_LAST) ? 4'h0 : sRow + 4'h1;
					end else begin
						speColQ[si] <= sCol + 9'h001;
						speRowQ[si] <= sRow;
					end
					tugQ <= (sCol == AU4_STUFF_LAST || tugQ == 2'h2) ? 2'h0 : tugQ + 2'h1;
				end
			end

			// flag high resets the phase; the partner owns its timing
			always_ff @(posedge ref_clk or negedge nrst) begin
				if (!nrst) begin
					mfPhaseQ <= 2'h0;
				end else if (advance && !c1Load) begin
					if (mfSample && mfNow[i]) begin
						mfPhaseQ <= V5_PHASE;
					end else if (isJ1 && si == 2'h0) begin
						mfPhaseQ <= mfPhaseQ + 2'h1;
					end
				end
			end

			// c1, j1 and j1 plus three only
			assign sFrame[i] = ((rowQ == C1_ROW) && (colQ == C1_COL)) || isJ1 || isV1m;
			assign sPay[i] = isPay;
			// tributary bytes exclude pointer bytes and stuff
			assign sTribPay[i] = isPay && tribArea && !vByte && groupOn;
			// overhead row across the four frames
			assign sPoh[i] = pohByte && groupOn;
			// v5 is the overhead byte of the first frame
			assign sStart[i] = pohByte && groupOn && (mfPhaseQ == V5_PHASE);
		end
	endgenerate

	////////////////////////////////////////////////////////////////
	// output register, stage seven
	// data leaves unmodified, bar the zeroed upper lanes in stm-4; only the marks depend on groups
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			out_data_bus <= 32'h00000000;
			out_frame_marker <= 4'h0;
			out_payload_ind <= 4'h0;
			out_trib_payload_ind <= 4'h0;
			out_trib_start_mark <= 4'h0;
			out_trib_overhead_mark <= 4'h0;
		end else if (stm1) begin
			// four lanes, seven edges end to end
			out_data_bus <= dataS6Q;
			out_frame_marker <= sFrame;
			out_payload_ind <= sPay;
			out_trib_payload_ind <= sTribPay;
			out_trib_start_mark <= sStart;
			out_trib_overhead_mark <= sPoh;
		end else begin
			// lane zero only, upper lanes held at zero
			out_data_bus <= {24'h000000, dataS6Q[7:0]};
			// stm-4 frame mark c1 comes from stream zero only
			out_frame_marker <= {3'h0, sFrame[slotQ] &
				(sPay[slotQ] || slotQ == 2'h0)};
			out_payload_ind <= {3'h0, sPay[slotQ]};
			out_trib_payload_ind <= {3'h0, sTribPay[slotQ]};
			out_trib_start_mark <= {3'h0, sStart[slotQ]};
			out_trib_overhead_mark <= {3'h0, sPoh[slotQ]};
		end
	end
endmodule // tributary_output_bus_timing
`default_nettype wire

// ### tb/tributary_output_bus_timing_properties.sv
`timescale 1ns/1ps
`default_nettype none
module tributary_output_bus_timing_checker (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic out_low_rate_select,
	input wire logic [31:0] in_data_bus,
	input wire logic [3:0] in_frame_marker,
	input wire logic [3:0] in_payload_ind,
	input wire logic [3:0] au4Mode,
	input wire logic [3:0][trib_out_pkg::GROUP_N-1:0] group_enable_bit,
	input wire logic [3:0][trib_out_pkg::GROUP_N-1:0] group_bypass_bit,
	input wire logic [31:0] out_data_bus,
	input wire logic [3:0] out_frame_marker,
	input wire logic [3:0] out_payload_ind,
	input wire logic [3:0] out_trib_payload_ind,
	input wire logic [3:0] out_trib_start_mark,
	input wire logic [3:0] out_trib_overhead_mark
);
	logic [3:0] upCnt_q;
	logic [13:0] gap_q;
	logic [1:0] seen_q;
	logic [3:0] allOff;
	logic hi, mk, py, c1Out;
	assign hi = out_low_rate_select;
	assign mk = out_frame_marker[0];
	assign py = out_payload_ind[0];
	assign c1Out = mk & ~py;
	////////////////////////////////////////////////////////////////
	// pipe history is only trusted once it holds post-reset bytes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) upCnt_q <= 4'h0;
		else if (upCnt_q != 4'hf) upCnt_q <= upCnt_q + 4'h1;
	end
	// first gap may be a free-running frame, so wait for two marks
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			gap_q <= 14'h0;
			seen_q <= 2'h0;
		end else if (c1Out) begin
			gap_q <= 14'h0;
			if (seen_q != 2'h2) seen_q <= seen_q + 2'h1;
		end else begin
			gap_q <= gap_q + 14'h1;
		end
	end
	always_comb begin
		for (int i = 0; i < 4; i++) allOff[i] = (group_enable_bit[i] & ~group_bypass_bit[i]) == 3'h0;
	end
	////////////////////////////////////////////////////////////////
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	property p_lane_data;
		hi && upCnt_q >= 4'h8 |-> out_data_bus == $past(in_data_bus, 7);
	endproperty
	a_lane_data: assert property (p_lane_data) else $error("lane data delay wrong");
	property p_stm4_lane;
		!hi && upCnt_q >= 4'h8 |-> out_data_bus == {24'h0, $past(in_data_bus[7:0], 7)};
	endproperty
	a_stm4_lane: assert property (p_stm4_lane) else $error("single lane output wrong");
	property p_c1_delay;
		hi && upCnt_q >= 4'h1 && in_frame_marker[0] && !in_payload_ind[0] |-> ##7 c1Out;
	endproperty
	a_c1_delay: assert property (p_c1_delay) else $error("frame mark delay wrong");
	property p_c1_gap;
		c1Out && seen_q == 2'h2 |-> gap_q == (hi ? 14'd2429 : 14'd9719);
	endproperty
	a_c1_gap: assert property (p_c1_gap) else $error("frame mark spacing wrong");
	property p_toh;
		hi && c1Out && seen_q != 2'h0 |-> ##1 !py ##1 !py ##1 py [*8];
	endproperty
	a_toh: assert property (p_toh) else $error("payload flag near frame mark wrong");
	property p_row_end;
		hi && c1Out && seen_q != 2'h0 |-> ##263 py ##1 !py [*8] ##1 !py ##1 py;
	endproperty
	a_row_end: assert property (p_row_end) else $error("payload flag at row edge wrong");
	property p_au3_trio;
		hi && !au4Mode[0] && upCnt_q >= 4'h8 && $rose(mk) && py |-> mk [*3] ##1 !mk;
	endproperty
	a_au3_trio: assert property (p_au3_trio) else $error("envelope marks not in threes");
	property p_au4_pair;
		hi && au4Mode[0] && upCnt_q >= 4'h8 && mk && py |-> $past(mk, 3) or (##[3:12] mk);
	endproperty
	a_au4_pair: assert property (p_au4_pair) else $error("single envelope mark unpaired");
	property p_start_oh;
		out_trib_start_mark[0] |->
			out_trib_overhead_mark[0] && out_trib_payload_ind[0] && out_payload_ind[0];
	endproperty
	a_start_oh: assert property (p_start_oh) else $error("start mark outside overhead");
	property p_trib_pay;
		(out_trib_payload_ind & ~out_payload_ind) == 4'h0;
	endproperty
	a_trib_pay: assert property (p_trib_pay) else $error("trib flag outside payload");
	property p_gate;
		upCnt_q >= 4'h8 |-> ((out_trib_payload_ind | out_trib_start_mark | out_trib_overhead_mark) & allOff) == 4'h0;
	endproperty
	a_gate: assert property (p_gate) else $error("gated group still marked");
	c_c1: cover property (c1Out);
	c_au4: cover property (hi && au4Mode[0] && mk && py);
	c_start: cover property (out_trib_start_mark[0]);
endmodule // tributary_output_bus_timing_checker
bind tributary_output_bus_timing tributary_output_bus_timing_checker chk (.ref_clk(ref_clk), .nrst(nrst),
	.out_low_rate_select(out_low_rate_select), .in_data_bus(in_data_bus),
	.in_frame_marker(in_frame_marker), .in_payload_ind(in_payload_ind), .au4Mode(au4Mode),
	.group_enable_bit(group_enable_bit), .group_bypass_bit(group_bypass_bit),
	.out_data_bus(out_data_bus), .out_frame_marker(out_frame_marker),
	.out_payload_ind(out_payload_ind), .out_trib_payload_ind(out_trib_payload_ind),
	.out_trib_start_mark(out_trib_start_mark), .out_trib_overhead_mark(out_trib_overhead_mark));
`default_nettype wire

// ### tb/mf_partner.sv
`timescale 1ns/1ps
`default_nettype none
module mf_partner (
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic c1Seen,
	output logic [3:0] mfFlag
);
	logic [1:0] frame_q;
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) frame_q <= 2'h0;
		else if (c1Seen) frame_q <= frame_q + 2'h1;
	end
	// whole-frame flag
	// held over the entire frame, so every sample point sees a settled level
	assign mfFlag = {4{frame_q == 2'h0}};
endmodule // mf_partner
`default_nettype wire

// ### tb/tributary_output_bus_timing_test.sv
`timescale 1ns/1ps
`default_nettype none
module tributary_output_bus_timing_test;
	import trib_out_pkg::*;
	logic ref_clk, nrst, out_low_rate_select;
	logic [31:0] in_data_bus, out_data_bus, expData;
	logic [3:0] in_frame_marker, in_payload_ind, out_multiframe_in, au4Mode, laneMask;
	logic [3:0][PTR_W-1:0] outPointer;
	logic [3:0][GROUP_N-1:0] group_enable_bit, group_bypass_bit;
	logic [3:0] out_frame_marker, out_payload_ind, out_trib_payload_ind;
	logic [3:0] out_trib_start_mark, out_trib_overhead_mark;
	int cyc, frLen, n_mismatch, checked, ticks;
	int nC1[4], accJ1[4], accPay[4], lastJ1[4], lastPay[4], trib[4], oh[4];
	tributary_output_bus_timing DUT (.ref_clk(ref_clk), .nrst(nrst),
		.out_low_rate_select(out_low_rate_select), .in_data_bus(in_data_bus),
		.in_frame_marker(in_frame_marker), .in_payload_ind(in_payload_ind),
		.out_multiframe_in(out_multiframe_in), .au4Mode(au4Mode), .outPointer(outPointer),
		.group_enable_bit(group_enable_bit), .group_bypass_bit(group_bypass_bit),
		.out_data_bus(out_data_bus), .out_frame_marker(out_frame_marker),
		.out_payload_ind(out_payload_ind), .out_trib_payload_ind(out_trib_payload_ind),
		.out_trib_start_mark(out_trib_start_mark), .out_trib_overhead_mark(out_trib_overhead_mark));
	mf_partner partner (.ref_clk(ref_clk), .nrst(nrst),
		.c1Seen(out_frame_marker[0] & ~out_payload_ind[0]), .mfFlag(out_multiframe_in));
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	function automatic logic [31:0] pat(input int c);
		pat = {c[7:0] ^ 8'hc3, c[7:0] ^ 8'h5a, ~c[7:0], c[7:0]};
	endfunction
	task automatic compare(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("compares %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// stream source: frame start on every lane at one shared instant
	always @(posedge ref_clk) begin
		cyc <= nrst ? cyc + 1 : 0;
		// bytes launched on the edge, c1 with payload low
		in_data_bus <= pat(cyc);
		in_frame_marker <= (nrst && cyc % frLen == 0) ? 4'hf : 4'h0;
		ticks <= ticks + 1;
		if (ticks > 50000) begin
			n_mismatch++;
			report_and_stop();
		end
	end
	always @(negedge ref_clk) begin
		if (nrst && cyc >= 8) begin
			laneMask = out_low_rate_select ? 4'hf : 4'h1;
			expData = pat(cyc - 8);
			if (!out_low_rate_select) expData = {24'h0, expData[7:0]};
			compare(out_data_bus, expData);
			if ((cyc - 8) % frLen == 0) compare(out_frame_marker & ~out_payload_ind & laneMask, laneMask);
			for (int i = 0; i < 4; i++) begin
				if (out_frame_marker[i] && !out_payload_ind[i]) begin
					if (nC1[i] > 0) lastJ1[i] = accJ1[i];
					if (nC1[i] > 0) lastPay[i] = accPay[i];
					nC1[i]++;
					accJ1[i] = 0;
					accPay[i] = 0;
				end else begin
					accJ1[i] += out_frame_marker[i] & out_payload_ind[i];
					accPay[i] += out_payload_ind[i];
				end
				trib[i] += out_trib_payload_ind[i];
				oh[i] += out_trib_overhead_mark[i];
			end
		end
	end
	task automatic run_phase();
		int expJ1;
		nrst <= 1'b0;
		repeat (20) @(posedge ref_clk);
		for (int i = 0; i < 4; i++) begin
			nC1[i] = 0;
			accJ1[i] = 0;
			accPay[i] = 0;
			trib[i] = 0;
			oh[i] = 0;
		end
		nrst <= 1'b1;
		repeat (3 * frLen + 20) @(posedge ref_clk);
		expJ1 = 0;
		for (int s = 0; s < 4; s++) expJ1 += au4Mode[s] ? 2 : 6;
		for (int i = 0; i < (out_low_rate_select ? 4 : 1); i++) begin
			compare(lastJ1[i], out_low_rate_select ? (au4Mode[i] ? 2 : 6) : expJ1);
			compare(lastPay[i], out_low_rate_select ? 2349 : 4 * 2349);
			compare(trib[i] > 0, (group_enable_bit[i] & ~group_bypass_bit[i]) != 3'h0);
			compare(oh[i] > 0, (group_enable_bit[i] & ~group_bypass_bit[i]) != 3'h0);
		end
		$display("phase done, compares so far %0d", checked);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		nrst = 1'b0;
		out_low_rate_select = 1'b1;
		in_payload_ind = 4'h0;
		in_data_bus = 32'h0;
		in_frame_marker = 4'h0;
		cyc = 0;
		ticks = 0;
		n_mismatch = 0;
		checked = 0;
		frLen = 2430;
		au4Mode = 4'ha;
		outPointer = {10'h30e, 10'h20a, 10'h064, 10'h000};
		group_enable_bit = {3'h7, 3'h0, 3'h7, 3'h7};
		group_bypass_bit = {3'h7, 3'h0, 3'h2, 3'h0};
		run_phase();
		au4Mode <= 4'h5;
		outPointer <= {10'h000, 10'h30e, 10'h1f4, 10'h051};
		group_enable_bit <= {3'h7, 3'h7, 3'h7, 3'h7};
		group_bypass_bit <= {3'h0, 3'h0, 3'h0, 3'h0};
		run_phase();
		// lane zero carries all four streams, so one frame spans four times the bytes
		out_low_rate_select <= 1'b0;
		frLen <= 9720;
		au4Mode <= 4'h6;
		run_phase();
		report_and_stop();
	end
endmodule // tributary_output_bus_timing_test
`default_nettype wire
